/* File: logic/aci_pkg.sv */
// Shared constants and types for the conversion output interface.
// Assumes a single 25 MHz system clock; every pin input is resynchronised.

package aci_pkg;

    // ********************************************************************
    // Widths and frame layout
    // ********************************************************************
    localparam int RES_W = 14;
    localparam int BYTE_W = 8;
    localparam int HI_W = 6;
    localparam int BUF_DEPTH = 2;
    localparam logic [3:0] FRAME_LAST = 4'hF;

    // ********************************************************************
    // Conversion timing
    // ********************************************************************
    localparam logic [4:0] CONV_EDGES = 5'h13;
    localparam int SYS_CLK_MHZ = 25;
    localparam int SYNC_WIN_NS = 30;
    localparam int SYNC_WIN_RAW = (SYNC_WIN_NS * SYS_CLK_MHZ) / 1000;
    localparam logic [2:0] SYNC_WIN_CYC = (SYNC_WIN_RAW < 1) ? 3'h1 : 3'(SYNC_WIN_RAW);

    // ********************************************************************
    // Format select codes
    // ********************************************************************
    localparam logic [1:0] FMT_SER_GATED = 2'h0;
    localparam logic [1:0] FMT_SER_CONT = 2'h1;
    localparam logic [1:0] FMT_PARALLEL = 2'h2;

    // ********************************************************************
    // Pin positions on the data bus
    // ********************************************************************
    localparam int PIN_HBS = 13;
    localparam int PIN_FRAME = 12;
    localparam int PIN_SCLK = 11;
    localparam int PIN_SERIAL_DATA_OUT = 10;

    // ********************************************************************
    // Synchroniser bit positions
    // ********************************************************************
    localparam int SY_MCLK = 0;
    localparam int SY_CST = 1;
    localparam int SY_CS = 2;
    localparam int SY_RD = 3;
    localparam int SY_HBS = 4;
    localparam int SY_FMT0 = 5;
    localparam int SY_FMT1 = 6;
    localparam int SY_PROC = 7;
    localparam int SY_SONLY = 8;
    localparam int SY_RUN = 9;
    localparam int SY_W = 10;

    // ********************************************************************
    // Reset values
    // ********************************************************************
    localparam logic INT_N_RST = 1'h0;
    localparam logic [SY_W-1:0] SYNC_RST = 10'h00F;

    // Conversion sequencer states
    typedef enum logic [1:0] {
        ACI_IDLE = 2'b00,
        ACI_CONV = 2'b01,
        ACI_STORE = 2'b10
    } aci_state_t;

endpackage : aci_pkg

/* File: logic/aci_buf.sv */
// Two-entry result buffer with valid/ready on both sides.
// Assumes producer and consumer share clk_sys.

`timescale 1ns/10ps
`default_nettype none

module aci_buf (
    input wire logic clk_sys,                          // System clock
    input wire logic srst,                             // Sync reset, high
    input wire logic in_valid,                         // Word offered
    output logic in_ready,                             // Room for a word
    input wire logic [aci_pkg::RES_W-1:0] in_data,     // Word in
    output logic out_valid,                            // Word available
    input wire logic out_ready,                        // Consumer takes word
    output logic [aci_pkg::RES_W-1:0] out_data         // Oldest word
);
    import aci_pkg::*;

    typedef struct packed {
        logic [BUF_DEPTH-1:0][RES_W-1:0] mem;
        logic wp;
        logic rp;
        logic [1:0] cnt;
    } aci_buf_st_t;

    aci_buf_st_t st_reg;
    aci_buf_st_t st_next;
    logic push;
    logic pop;

    // Handshake decode
    assign in_ready = (st_reg.cnt != 2'h2);
    assign out_valid = (st_reg.cnt != 2'h0);
    assign out_data = st_reg.mem[st_reg.rp];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Pointer and count update
    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wp] = in_data;
            st_next.wp = ~st_reg.wp;
        end
        if (pop) begin
            st_next.rp = ~st_reg.rp;
        end
        case ({push, pop})
            2'b10: st_next.cnt = 2'(st_reg.cnt + 2'h1);
            2'b01: st_next.cnt = 2'(st_reg.cnt - 2'h1);
            default: st_next.cnt = st_reg.cnt;
        endcase
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule : aci_buf

`default_nettype wire

/* File: logic/aci_core.sv */
// Conversion control, busy/interrupt, parallel/byte read and framed serial output.
// Assumes pins arrive asynchronously and the sampler core result is on clk_sys.
//
// Functional notes
// - Format select low/negative turns pins serial
// - Serial word: two zeros then 14 bits
// - Data changes on rising serial clock
// - Frame strobe low at conversion start
// - Serial pins only pull low
// - Serial clock follows master clock
// - Negative: clock runs; zero: released after word
// - Serial-only part: clock-run pin same choice
// - Start pulse rising edge holds and converts
// - Timed mode: interrupt low at completion
// - Read falling edge returns interrupt high
// - Interrupt low after power-up; dummy read clears
// - Parallel format: one 14-bit read, no serial
// - Byte read picks byte, clears interrupt
// - Processor mode: select low, byte-select low starts
// - Processor mode: busy low through conversion
// - Parallel processor read waits, then delivers
// - Serial output same in both modes
// - High byte right-justified, top bits zero
// - Conversion lasts 19 or 20 master edges
// - Result is twos-complement, passed unchanged

`timescale 1ns/10ps
`default_nettype none

module aci_core (
    input wire logic clk_sys,                              // 25 MHz system clock
    input wire logic srst,                                 // Sync reset, high
    input wire logic mclk_in,                              // Converter master clock
    input wire logic conversion_start_n,                   // Start pulse, low going
    input wire logic cs_n,                                 // Chip select, low
    input wire logic rd_n,                                 // Read strobe, low
    input wire logic [1:0] fmt_sel,                        // Output format strap
    input wire logic proc_start_mode,                      // Start from chip select
    input wire logic serial_only,                          // Serial-only variant strap
    input wire logic clk_run_select,                       // Serial-only clock run
    input wire logic msb_or_byte_select_pin,               // Pin 13 input side
    input wire logic [aci_pkg::RES_W-1:0] core_result,     // Sampler core result
    output logic [aci_pkg::RES_W-1:0] db_out,              // Bus pin levels
    output logic [aci_pkg::RES_W-1:0] db_oe_n,             // Bus pin enables, low drives
    output logic busy_int_n,                               // Busy or interrupt, low
    output logic sampler_hold                              // Sampler in hold
);
    import aci_pkg::*;

    // ********************************************************************
    // State record
    // ********************************************************************
    typedef struct packed {
        logic [SY_W-1:0] s1;
        logic [SY_W-1:0] s2;
        logic [SY_W-1:0] s3;
        aci_state_t state;
        logic [4:0] edge_cnt;
        logic extra;
        logic [2:0] win;
        logic frame;
        logic fell_seen;
        logic [3:0] bit_cnt;
        logic [15:0] shreg;
        logic [RES_W-1:0] res;
        logic pop_ok;
        logic bi_n;
        logic hold;
        logic [RES_W-1:0] dout;
        logic [RES_W-1:0] doe_n;
    } aci_core_st_t;

    aci_core_st_t st_reg;
    aci_core_st_t st_next;

    logic [SY_W-1:0] pins;
    logic mclk;
    logic mclk_rise;
    logic mclk_fall;
    logic [1:0] fmt;
    logic ser_mode;
    logic par_mode;
    logic cont_clk;
    logic proc_mode;
    logic hbs;
    logic rd_act;
    logic rd_prev;
    logic rd_fall;
    logic rd_rise;
    logic cs_fall;
    logic cst_rise;
    logic idle;
    logic start_req;
    logic done_push;
    logic pop;
    logic rd_drive;
    logic [4:0] edge_inc;
    logic [4:0] edge_target;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [RES_W-1:0] head;

    // ********************************************************************
    // Pin decode, all from the second synchroniser stage onward
    // ********************************************************************
    assign pins = {clk_run_select, serial_only, proc_start_mode, fmt_sel,
                   msb_or_byte_select_pin, rd_n, cs_n, conversion_start_n, mclk_in};
    assign mclk = st_reg.s2[SY_MCLK];
    assign mclk_rise = mclk & ~st_reg.s3[SY_MCLK];
    assign mclk_fall = ~mclk & st_reg.s3[SY_MCLK];
    assign fmt = {st_reg.s2[SY_FMT1], st_reg.s2[SY_FMT0]};
    assign ser_mode = st_reg.s2[SY_SONLY] | (fmt != FMT_PARALLEL);
    assign par_mode = ~ser_mode;
    // Clock-run choice from format strap or dedicated pin
    assign cont_clk = st_reg.s2[SY_SONLY] ? st_reg.s2[SY_RUN]
                                          : (fmt == FMT_SER_CONT);
    assign proc_mode = st_reg.s2[SY_PROC] & ~st_reg.s2[SY_SONLY];
    assign hbs = par_mode ? 1'h0 : st_reg.s2[SY_HBS];
    assign rd_act = ~st_reg.s2[SY_CS] & ~st_reg.s2[SY_RD];
    assign rd_prev = ~st_reg.s3[SY_CS] & ~st_reg.s3[SY_RD];
    assign rd_fall = rd_act & ~rd_prev;
    assign rd_rise = ~rd_act & rd_prev;
    assign cs_fall = ~st_reg.s2[SY_CS] & st_reg.s3[SY_CS];
    assign cst_rise = st_reg.s2[SY_CST] & ~st_reg.s3[SY_CST];
    assign idle = (st_reg.state == ACI_IDLE);

    // Start source; starts while busy are ignored
    assign start_req = idle & (proc_mode ? (cs_fall & ~hbs) : cst_rise);
    assign done_push = (st_reg.state == ACI_STORE) & buf_in_ready;
    // Bus held off until conversion is stored
    // A read that starts a conversion waits for the stored word, not stale data
    assign rd_drive = rd_act & idle & ~start_req;
    // Word leaves buffer after full read or high byte
    assign pop = rd_rise & st_reg.pop_ok & buf_out_valid;
    assign edge_inc = 5'(st_reg.edge_cnt + 5'h01);
    assign edge_target = 5'(CONV_EDGES + {4'h0, st_reg.extra});

    // ********************************************************************
    // Result buffer
    // ********************************************************************
    aci_buf u_buf (
        .clk_sys(clk_sys),
        .srst(srst),
        .in_valid(st_reg.state == ACI_STORE),
        .in_ready(buf_in_ready),
        .in_data(st_reg.res),
        .out_valid(buf_out_valid),
        .out_ready(pop),
        .out_data(head)
    );

    // ********************************************************************
    // Next-state logic
    // ********************************************************************
    always_comb begin
        st_next = st_reg;
        // Synchroniser chain and edge history
        st_next.s1 = pins;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;

        // Conversion sequencer
        case (st_reg.state)
            ACI_IDLE: begin
                if (start_req) begin
                    st_next.state = ACI_CONV;
                    st_next.edge_cnt = 5'h00;
                    st_next.extra = mclk_rise;
                    st_next.win = 3'h1;
                    st_next.res = core_result;
                    st_next.hold = 1'h1;
                end
            end
            ACI_CONV: begin
                if (mclk_rise) begin
                    st_next.edge_cnt = edge_inc;
                    if (st_reg.win < SYNC_WIN_CYC) begin
                        st_next.extra = 1'h1;
                    end
                    if (edge_inc == edge_target) begin
                        st_next.state = ACI_STORE;
                    end
                end
                if (st_reg.win != 3'h7) begin
                    st_next.win = 3'(st_reg.win + 3'h1);
                end
            end
            ACI_STORE: begin
                if (buf_in_ready) begin
                    st_next.state = ACI_IDLE;
                    st_next.hold = 1'h0;
                end
            end
            default: begin
                st_next.state = ACI_IDLE;
                st_next.hold = 1'h0;
            end
        endcase

        // Serial frame, identical in both start modes
        if (start_req) begin
            st_next.frame = ser_mode;
            st_next.fell_seen = mclk_fall;
            st_next.bit_cnt = 4'h0;
            st_next.shreg = {2'h0, core_result};
        end else if (st_reg.frame) begin
            if (mclk_fall) begin
                st_next.fell_seen = 1'h1;
            end
            if (mclk_rise && st_reg.fell_seen) begin
                if (st_reg.bit_cnt == FRAME_LAST) begin
                    st_next.frame = 1'h0;
                end else begin
                    st_next.shreg = {st_reg.shreg[14:0], 1'h0};
                    st_next.bit_cnt = 4'(st_reg.bit_cnt + 4'h1);
                end
            end
        end

        // Busy in processor mode, sticky interrupt otherwise
        if (proc_mode) begin
            st_next.bi_n = ~(start_req | (~idle & ~done_push));
        end else if (done_push) begin
            st_next.bi_n = 1'h0;
        end else if (rd_fall) begin
            st_next.bi_n = 1'h1;
        end

        // Remember whether this read consumes the word
        if (rd_fall) begin
            st_next.pop_ok = par_mode | hbs;
        end else if (rd_rise) begin
            st_next.pop_ok = 1'h0;
        end

        // Bus pins, released by default
        st_next.dout = '0;
        st_next.doe_n = '1;
        if (par_mode) begin
            if (rd_drive) begin
                st_next.dout = head;
                st_next.doe_n = '0;
            end
        end else begin
            if (rd_drive) begin
                // Byte read on the low eight lines
                for (int i = 0; i < BYTE_W; i++) begin
                    st_next.dout[i] = hbs ? ((i < HI_W) ? head[BYTE_W + i] : 1'h0)
                                          : head[i];
                    st_next.doe_n[i] = 1'h0;
                end
            end
            // Open-drain serial pins: enable low pulls line low
            st_next.doe_n[PIN_FRAME] = ~st_next.frame;
            st_next.doe_n[PIN_SERIAL_DATA_OUT] = ~(st_next.frame & ~st_next.shreg[15]);
            // Gated clock only falls once the frame has counted that fall
            st_next.doe_n[PIN_SCLK] = ~((cont_clk | (st_next.frame & st_next.fell_seen))
                                        & ~mclk);
        end
    end

    // ********************************************************************
    // State register
    // ********************************************************************
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_reg <= '0;
            st_reg.s1 <= SYNC_RST;
            st_reg.s2 <= SYNC_RST;
            st_reg.s3 <= SYNC_RST;
            st_reg.state <= ACI_IDLE;
            st_reg.bi_n <= INT_N_RST;
            st_reg.doe_n <= '1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state record
    assign db_out = st_reg.dout;
    assign db_oe_n = st_reg.doe_n;
    assign busy_int_n = st_reg.bi_n;
    assign sampler_hold = st_reg.hold;

    // ********************************************************************
    // Checks
    // ********************************************************************
    chk_hold_start: assert property (@(posedge clk_sys) disable iff (srst)
        start_req |=> (sampler_hold && st_reg.state == ACI_CONV))
        else $error("sampler did not hold at start");

    chk_lead_zero: assert property (@(posedge clk_sys) disable iff (srst)
        start_req |=> (st_reg.shreg == {2'h0, $past(core_result)}))
        else $error("serial word not two zeros plus result");

    chk_frame_low: assert property (@(posedge clk_sys) disable iff (srst)
        (start_req && ser_mode) |=> (!db_oe_n[PIN_FRAME] && !db_oe_n[PIN_SERIAL_DATA_OUT]))
        else $error("frame strobe or first zero missing at start");

    chk_serial_shift: assert property (@(posedge clk_sys) disable iff (srst)
        (st_reg.frame && !start_req && mclk_rise && st_reg.fell_seen
            && st_reg.bit_cnt != FRAME_LAST)
        |=> (st_reg.shreg == {$past(st_reg.shreg[14:0]), 1'h0}))
        else $error("serial data did not advance on rising clock");

    chk_frame_end: assert property (@(posedge clk_sys) disable iff (srst)
        (st_reg.frame && !start_req && mclk_rise && st_reg.fell_seen
            && st_reg.bit_cnt == FRAME_LAST) |=> (!st_reg.frame ##0 db_oe_n[PIN_FRAME]))
        else $error("frame not closed after sixteenth bit");

    chk_od_pull: assert property (@(posedge clk_sys) disable iff (srst)
        ser_mode |=> (db_out[PIN_FRAME:PIN_SERIAL_DATA_OUT] == 3'h0))
        else $error("open-drain pin driven high");

    chk_gated_release: assert property (@(posedge clk_sys) disable iff (srst)
        (ser_mode && !cont_clk && !st_reg.frame && !start_req) |=> db_oe_n[PIN_SCLK])
        else $error("gated serial clock not released");

    chk_cont_clock: assert property (@(posedge clk_sys) disable iff (srst)
        (ser_mode && cont_clk && !mclk) |=> !db_oe_n[PIN_SCLK])
        else $error("continuous serial clock stopped");

    chk_conv_end: assert property (@(posedge clk_sys) disable iff (srst)
        (st_reg.state == ACI_CONV && mclk_rise) |-> (st_reg.edge_cnt < edge_target))
        else $error("conversion overran its edge count");

    chk_int_set: assert property (@(posedge clk_sys) disable iff (srst)
        (done_push && !proc_mode) |=> !busy_int_n)
        else $error("interrupt not raised at completion");

    chk_int_clear: assert property (@(posedge clk_sys) disable iff (srst)
        (rd_fall && !done_push && !proc_mode) |=> busy_int_n)
        else $error("interrupt not cleared by read");

    chk_busy_low: assert property (@(posedge clk_sys) disable iff (srst)
        (proc_mode && start_req) |=> (!busy_int_n && st_reg.state == ACI_CONV))
        else $error("busy not low at start");

    chk_par_quiet: assert property (@(posedge clk_sys) disable iff (srst)
        (par_mode && !rd_act) |=> (db_oe_n == '1))
        else $error("parallel format drives pins outside a read");

endmodule : aci_core

`default_nettype wire

/* File: verif/aci_host_rx.sv */
// Host serial receiver model for the conversion output interface.
// Assumes pin levels already resolved with pull-ups, sampled on clk_sys.
`timescale 1ns/10ps
`default_nettype none

module aci_host_rx (
    input wire logic clk_sys,   // System clock
    input wire logic clr,       // Clear word and count
    input wire logic frame_n,   // Frame strobe pin level
    input wire logic sclk,      // Serial clock pin level
    input wire logic serial_data_out,     // Serial data pin level
    output logic [15:0] word,   // Received word
    output logic [4:0] nbits    // Bits taken in frame
);
    // ********************************************************************
    // Receive shift
    // ********************************************************************
    logic prev = 1'b1;

    // Shift in on each falling serial clock inside the frame
    always_ff @(posedge clk_sys) begin
        prev <= sclk;
        if (clr) begin
            word <= 16'h0000;
            nbits <= 5'h00;
        end else if (prev && !sclk && !frame_n) begin
            word <= {word[14:0], serial_data_out};
            nbits <= nbits + 5'h01;
        end
    end
endmodule : aci_host_rx
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the conversion output interface.
// Assumes aci_core as the device and aci_host_rx as the serial host.
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import aci_pkg::*;

    // ********************************************************************
    // Signals and instances
    // ********************************************************************
    logic clk_sys = 1'b0, srst = 1'b1, mclk_in = 1'b0, clr = 1'b1, k;
    logic cst_n = 1'b1, cs_n = 1'b1, rd_n = 1'b1, hbs = 1'b0, bz = 1'b0;
    logic pm = 1'b0, so = 1'b0, crs = 1'b0;
    logic [1:0] fmt_sel = FMT_PARALLEL;
    logic [RES_W-1:0] res = 14'h0000, d, db_out, db_oe_n;
    logic busy_int_n, sampler_hold;
    logic [15:0] word;
    logic [4:0] nbits;
    int errors = 0, compares = 0, n;
    // Pin levels: open-drain lines pulled up when released
    wire logic fr_pin = db_oe_n[PIN_FRAME] ? 1'b1 : db_out[PIN_FRAME];
    wire logic sck_pin = db_oe_n[PIN_SCLK] ? 1'b1 : db_out[PIN_SCLK];
    wire logic sd_pin = db_oe_n[PIN_SERIAL_DATA_OUT] ? 1'b1 : db_out[PIN_SERIAL_DATA_OUT];
    wire logic hb_pin = db_oe_n[PIN_HBS] ? hbs : db_out[PIN_HBS];

    // System clock and unrelated master clock
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        #7;
        forever #160 mclk_in = ~mclk_in;
    end

    aci_core i_aci_core (.clk_sys, .srst, .mclk_in, .conversion_start_n(cst_n), .cs_n, .rd_n,
        .fmt_sel, .proc_start_mode(pm), .serial_only(so), .clk_run_select(crs),
        .msb_or_byte_select_pin(hb_pin), .core_result(res), .db_out, .db_oe_n,
        .busy_int_n, .sampler_hold);
    aci_host_rx i_aci_host_rx (.clk_sys, .clr, .frame_n(fr_pin), .sclk(sck_pin),
        .serial_data_out(sd_pin), .word, .nbits);

    // ********************************************************************
    // Tasks
    // ********************************************************************
    task automatic conclude;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic cyc(input int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask : cyc

    task automatic tmo(input int i, input int lim);
        if (i >= lim) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, i, lim);
            conclude();
        end
    endtask : tmo

    // Start pulse, only while idle; waits for hold
    task automatic start(input logic [13:0] r);
        int i;
        res = r;
        cst_n = 1'b0;
        cyc(3);
        cst_n = 1'b1;
        for (i = 0; i < 20 && sampler_hold !== 1'b1; i++) cyc(1);
        tmo(i, 20);
    endtask : start

    task automatic done(output int c);
        for (c = 0; c < 400 && sampler_hold === 1'b1; c++) cyc(1);
        tmo(c, 400);
    endtask : done

    // Read cycle held until the bus is driven; start line stays high
    task automatic rd(input logic hb, output logic [13:0] v);
        int i;
        hbs = hb;
        cs_n = 1'b0;
        rd_n = 1'b0;
        for (i = 0; i < 400 && db_oe_n[0] !== 1'b0; i++) begin
            if (busy_int_n === 1'b0) bz = 1'b1;
            cyc(1);
        end
        tmo(i, 400);
        v = db_out;
        cs_n = 1'b1;
        rd_n = 1'b1;
        cyc(4);
    endtask : rd

    task automatic setup(input logic [1:0] f, input logic s, input logic c, input logic p);
        logic cr;
        // Continuous serial clock may legally be pulling its pin low here
        cr = s ? c : (f == FMT_SER_CONT);
        fmt_sel = f;
        so = s;
        crs = c;
        pm = p;
        srst = 1'b1;
        cyc(3);
        srst = 1'b0;
        cyc(8);
        chk(db_oe_n | (14'(cr) << PIN_SCLK), 14'h3FFF);
        if (!p && !s) begin
            chk(busy_int_n, 1'b0);
            rd(1'b0, d);
            chk(busy_int_n, 1'b1);
        end
    endtask : setup

    task automatic ser(input logic [13:0] r, input logic cont);
        int m;
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        start(r);
        done(m);
        chk(word, {2'b00, r});
        chk(nbits, 5'h10);
        chk(fr_pin, 1'b1);
        chk(db_out[12:10], 3'h0);
        k = 1'b0;
        repeat (10) begin
            if (db_oe_n[PIN_SCLK] === 1'b0) k = 1'b1;
            cyc(1);
        end
        chk(k, cont);
    endtask : ser

    // ********************************************************************
    // Test sequence
    // ********************************************************************
    initial begin
        cyc(16);
        setup(FMT_PARALLEL, 1'b0, 1'b0, 1'b0);
        start(14'h2A5C);
        chk(db_oe_n[12:10], 3'h7);
        done(n);
        chk(n >= 144 && n <= 170, 1'b1);
        chk(busy_int_n, 1'b0);
        start(14'h1337);
        done(n);
        rd(1'b0, d);
        chk(d, 14'h2A5C);
        chk(busy_int_n, 1'b1);
        rd(1'b0, d);
        chk(d, 14'h1337);
        repeat (2) begin
            start(14'h0C0F);
            done(n);
        end
        start(14'h0C0F);
        cyc(200);
        chk(sampler_hold, 1'b1);
        $display("test parallel done");
        setup(FMT_SER_GATED, 1'b0, 1'b0, 1'b0);
        ser(14'h3D96, 1'b0);
        rd(1'b0, d);
        chk(d[7:0], 8'h96);
        rd(1'b1, d);
        chk(d[7:0], 8'h3D);
        $display("test byte gated done");
        setup(FMT_SER_CONT, 1'b0, 1'b0, 1'b0);
        ser(14'h0421, 1'b1);
        setup(FMT_PARALLEL, 1'b1, 1'b0, 1'b0);
        ser(14'h3FFF, 1'b0);
        setup(FMT_PARALLEL, 1'b1, 1'b1, 1'b0);
        ser(14'h2000, 1'b1);
        $display("test serial clock done");
        setup(FMT_PARALLEL, 1'b0, 1'b0, 1'b1);
        res = 14'h1A2B;
        bz = 1'b0;
        rd(1'b0, d);
        chk(d, 14'h1A2B);
        chk(bz, 1'b1);
        chk(busy_int_n, 1'b1);
        setup(FMT_SER_GATED, 1'b0, 1'b0, 1'b1);
        res = 14'h35AA;
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        rd(1'b0, d);
        chk(d[7:0], 8'hAA);
        chk(word, 16'h35AA);
        rd(1'b1, d);
        chk(d[7:0], 8'h35);
        $display("test processor mode done");
        conclude();
    end
endmodule : testbench
`default_nettype wire
